// ===== bsq_pkg.sv
package bsq_pkg;

  localparam int          DATA_W            = 8;
  localparam int          REG_AW            = 4;

  // device command codes
  localparam logic [7:0]  CMD_ERASE_SETUP   = 8'h20;
  localparam logic [7:0]  CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0]  CMD_READ_ARRAY    = 8'hff;
  localparam logic [7:0]  CMD_CLEAR_STATUS  = 8'h50;

  // device status_reg bit positions
  localparam int          SR_READY_BIT      = 7;
  localparam int          SR_ERASE_BIT      = 5;
  localparam int          SR_SEQ_BIT        = 4;
  localparam int          SR_SUPPLY_BIT     = 3;
  localparam int          SR_LOCK_BIT       = 1;

  // controller register offsets
  localparam logic [3:0]  REG_CTRL          = 4'h0;
  localparam logic [3:0]  REG_ADDR          = 4'h1;
  localparam logic [3:0]  REG_DEV_STAT      = 4'h2;
  localparam logic [3:0]  REG_IRQ_STAT      = 4'h3;
  localparam logic [3:0]  REG_IRQ_MASK      = 4'h4;
  localparam logic [3:0]  REG_CFG           = 4'h5;

  localparam int          CTRL_START        = 0;
  localparam int          CTRL_CLEAR        = 1;
  localparam int          CTRL_ARRAY        = 2;
  localparam int          CFG_AUTO_ARRAY    = 0;
  localparam logic        CFG_AUTO_RESET    = 1'b1;

  localparam int          IRQ_W             = 6;
  localparam int          IRQ_DONE          = 0;
  localparam int          IRQ_SUPPLY        = 1;
  localparam int          IRQ_SEQ           = 2;
  localparam int          IRQ_ERASE         = 3;
  localparam int          IRQ_LOCK          = 4;
  localparam int          IRQ_REFUSED       = 5;

  // pin timing, ns, and cycles at the 8 ns system clock
  localparam int          CLK_NS            = 8;
  localparam int          T_SETUP_NS        = 20;
  localparam int          T_WE_NS           = 50;
  localparam int          T_HOLD_NS         = 20;
  localparam int          T_ACC_NS          = 100;
  localparam int          T_GAP_NS          = 30;
  localparam int          SYNC_LAT          = 4;
  localparam logic [7:0]  SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  WE_CYC    = 8'((T_WE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  HOLD_CYC  = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  GAP_CYC   = 8'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  RD_CYC    =
    8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);
  localparam logic [7:0]  CNT_ONE   = 8'h01;

  typedef enum logic [2:0] {
    S_IDLE, S_WSETUP, S_WPULSE, S_WHOLD, S_WGAP, S_RACC, S_RGAP
  } bsq_state_t;

  typedef enum logic [2:0] {
    OP_SETUP, OP_CONFIRM, OP_POLL, OP_CLEAR, OP_ARRAY
  } bsq_op_t;

endpackage : bsq_pkg

// ===== bsq_sync.sv
`timescale 1ns/1ns
module bsq_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] ff1_q;
  logic [W-1:0] ff2_q;
  logic [W-1:0] ff3_q;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ff1_q <= '0;
      ff2_q <= '0;
      ff3_q <= '0;
    end else begin
      ff1_q <= d_i;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
    end
  end

  // a bit moves only once the second and third stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        q_o[i] <= 1'b0;
      end else if (ff2_q[i] == ff3_q[i]) begin
        q_o[i] <= ff3_q[i];
      end
    end
  end

endmodule : bsq_sync

// ===== bsq_ctrl.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module bsq_ctrl
  import bsq_pkg::*;
#(
  parameter int ADDR_W = 21
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic [REG_AW-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  output logic                   irq_o,
  output logic      [ADDR_W-1:0] flash_addr_o,
  output logic      [DATA_W-1:0] flash_dq_o,
  output logic                   flash_dq_oe_o,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  output logic                   flash_ce_n_o,
  output logic                   flash_oe_n_o,
  output logic                   flash_we_n_o
);

  function automatic logic is_write(input bsq_state_t st);
    return st inside {S_WSETUP, S_WPULSE, S_WHOLD};
  endfunction : is_write

  function automatic logic is_wr(input logic [REG_AW-1:0] off);
    return reg_wr_i && reg_addr_i == off;
  endfunction : is_wr

  bsq_state_t        state_q, state_d;
  bsq_op_t           op_q, op_d;
  logic [7:0]        cnt_q, cnt_d;
  logic [ADDR_W-1:0] blk_addr_q;
  logic [DATA_W-1:0] dev_stat_q;
  logic [DATA_W-1:0] dq_sync;
  logic [IRQ_W-1:0]  irq_stat_q, irq_ev, irq_clr;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic              auto_array_q;
  logic              hold_q;
  logic              start_req, clear_req, array_req, refuse;
  logic              rd_sample, ready_now, cnt_end;

  bsq_sync #(.W(DATA_W)) u_dq_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (flash_dq_i),
    .q_o       (dq_sync)
  );

  //////////////////////////////////////////////////////////////////////////
  // command requests from software
  assign start_req = is_wr(REG_CTRL) && reg_wdata_i[CTRL_START];
  assign clear_req = is_wr(REG_CTRL) && reg_wdata_i[CTRL_CLEAR];
  assign array_req = is_wr(REG_CTRL) && reg_wdata_i[CTRL_ARRAY];
  // locked or supply error still pending: erase not allowed
  assign refuse    = start_req && state_q == S_IDLE && hold_q;
  assign cnt_end   = cnt_q == CNT_ONE;
  assign rd_sample = state_q == S_RACC && cnt_end;
  assign ready_now = dq_sync[SR_READY_BIT];

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    cnt_d   = cnt_q - CNT_ONE;
    unique case (state_q)
      S_IDLE: begin
        cnt_d = SETUP_CYC;
        if (start_req && !hold_q) begin
          state_d = S_WSETUP;
          op_d    = OP_SETUP;
        end else if (clear_req) begin
          state_d = S_WSETUP;
          op_d    = OP_CLEAR;
        end else if (array_req) begin
          state_d = S_WSETUP;
          op_d    = OP_ARRAY;
        end
      end
      S_WSETUP: if (cnt_end) begin
        state_d = S_WPULSE;
        cnt_d   = WE_CYC;
      end
      S_WPULSE: if (cnt_end) begin
        state_d = S_WHOLD;
        cnt_d   = HOLD_CYC;
      end
      S_WHOLD: if (cnt_end) begin
        state_d = S_WGAP;
        cnt_d   = GAP_CYC;
      end
      S_WGAP: if (cnt_end) begin
        unique case (op_q)
          OP_SETUP: begin
            state_d = S_WSETUP;
            op_d    = OP_CONFIRM;
            cnt_d   = SETUP_CYC;
          end
          OP_CONFIRM: begin
            // status comes back on every read, no read-status command
            state_d = S_RACC;
            op_d    = OP_POLL;
            cnt_d   = RD_CYC;
          end
          default: state_d = S_IDLE;
        endcase
      end
      S_RACC: if (cnt_end) begin
        state_d = S_RGAP;
        cnt_d   = GAP_CYC;
      end
      S_RGAP: if (cnt_end) begin
        if (!dev_stat_q[SR_READY_BIT]) begin
          state_d = S_RACC;
          cnt_d   = RD_CYC;
        end else if (auto_array_q) begin
          state_d = S_WSETUP;
          op_d    = OP_ARRAY;
          cnt_d   = SETUP_CYC;
        end else begin
          state_d = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= S_IDLE;
      op_q    <= OP_SETUP;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      cnt_q   <= cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flash pins, registered from the next state
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flash_ce_n_o  <= 1'b1;
      flash_oe_n_o  <= 1'b1;
      flash_we_n_o  <= 1'b1;
      flash_dq_oe_o <= 1'b0;
      flash_dq_o    <= '0;
      flash_addr_o  <= '0;
    end else begin
      // gaps raise both enables so the device refreshes status
      flash_ce_n_o  <= !(is_write(state_d) || state_d == S_RACC);
      flash_oe_n_o  <= state_d != S_RACC;
      flash_we_n_o  <= state_d != S_WPULSE;
      flash_dq_oe_o <= is_write(state_d);
      flash_addr_o  <= blk_addr_q;
      unique case (op_d)
        OP_SETUP:   flash_dq_o <= CMD_ERASE_SETUP;
        OP_CONFIRM: flash_dq_o <= CMD_ERASE_CONFIRM;
        OP_CLEAR:   flash_dq_o <= CMD_CLEAR_STATUS;
        OP_ARRAY:   flash_dq_o <= CMD_READ_ARRAY;
        OP_POLL:    flash_dq_o <= flash_dq_o;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status capture and full status check
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dev_stat_q <= '0;
    end else if (rd_sample) begin
      dev_stat_q <= dq_sync;
    end
  end

  always_comb begin
    irq_ev = '0;
    if (rd_sample && ready_now) begin
      irq_ev[IRQ_DONE]   = 1'b1;
      irq_ev[IRQ_SUPPLY] = dq_sync[SR_SUPPLY_BIT];
      irq_ev[IRQ_SEQ]    = dq_sync[SR_SEQ_BIT] && dq_sync[SR_ERASE_BIT];
      irq_ev[IRQ_ERASE]  = !dq_sync[SR_SEQ_BIT] && dq_sync[SR_ERASE_BIT];
      irq_ev[IRQ_LOCK]   = dq_sync[SR_LOCK_BIT];
    end
    irq_ev[IRQ_REFUSED]  = refuse;
  end

  // mirrors the device: pending until clear-status is written
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_q <= 1'b0;
    end else if (irq_ev[IRQ_LOCK] || irq_ev[IRQ_SUPPLY]) begin
      hold_q <= 1'b1;
    end else if (state_q == S_WGAP && op_q == OP_CLEAR && cnt_end) begin
      hold_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software registers and interrupt
  assign irq_clr = is_wr(REG_IRQ_STAT) ? reg_wdata_i[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat_q <= '0;
    end else begin
      // a new event outranks a simultaneous clear
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      blk_addr_q   <= '0;
      irq_mask_q   <= '0;
      auto_array_q <= CFG_AUTO_RESET;
    end else begin
      if (is_wr(REG_ADDR) && state_q == S_IDLE) begin
        blk_addr_q <= reg_wdata_i[ADDR_W-1:0];
      end
      if (is_wr(REG_IRQ_MASK)) begin
        irq_mask_q <= reg_wdata_i[IRQ_W-1:0];
      end
      if (is_wr(REG_CFG)) begin
        auto_array_q <= reg_wdata_i[CFG_AUTO_ARRAY];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o       <= 1'b0;
      reg_rdata_o <= '0;
    end else begin
      irq_o       <= |(irq_stat_q & irq_mask_q);
      reg_rdata_o <= '0;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          REG_CTRL:     reg_rdata_o <= {30'h0, hold_q, state_q != S_IDLE};
          REG_ADDR:     reg_rdata_o <= 32'(blk_addr_q);
          REG_DEV_STAT: reg_rdata_o <= 32'(dev_stat_q);
          REG_IRQ_STAT: reg_rdata_o <= 32'(irq_stat_q);
          REG_IRQ_MASK: reg_rdata_o <= 32'(irq_mask_q);
          REG_CFG:      reg_rdata_o <= 32'(auto_array_q);
          default:      reg_rdata_o <= '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_setup_sent;
    state_q == S_WGAP && op_q == OP_SETUP && cnt_end;
  endsequence

  sequence s_confirm_start;
    state_q == S_WSETUP && op_q == OP_CONFIRM;
  endsequence

  property p_setup_code;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_q == S_WPULSE && op_q == OP_SETUP) |->
        !flash_we_n_o && !flash_ce_n_o && flash_dq_oe_o &&
        flash_dq_o == CMD_ERASE_SETUP && flash_addr_o == blk_addr_q;
  endproperty
  a_setup_code: assert property (p_setup_code)
    else $error("setup code not on the pins during write pulse");

  property p_confirm_next;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      s_setup_sent |=> s_confirm_start ##1 flash_dq_o == CMD_ERASE_CONFIRM;
  endproperty
  a_confirm_next: assert property (p_confirm_next)
    else $error("confirm write did not follow setup write");

  property p_busy_repoll;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_q == S_RGAP && cnt_end && !dev_stat_q[SR_READY_BIT]) |=>
        state_q == S_RACC && cnt_q == RD_CYC;
  endproperty
  a_busy_repoll: assert property (p_busy_repoll)
    else $error("busy status did not start another read");

  property p_toggle;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      rd_sample |=> (flash_ce_n_o && flash_oe_n_o)[*2];
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("enables not raised between status reads");

  property p_supply;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (rd_sample && ready_now && dq_sync[SR_SUPPLY_BIT]) |=>
        irq_stat_q[IRQ_SUPPLY] && hold_q;
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply error not flagged");

  property p_erase_err;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (rd_sample && ready_now) |=>
        irq_stat_q[IRQ_SEQ] >= $past(dq_sync[SR_SEQ_BIT] &&
          dq_sync[SR_ERASE_BIT]) &&
        irq_stat_q[IRQ_ERASE] >= $past(!dq_sync[SR_SEQ_BIT] &&
          dq_sync[SR_ERASE_BIT]);
  endproperty
  a_erase_err: assert property (p_erase_err)
    else $error("sequence or erase error misclassified");

  property p_refuse;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_q == S_IDLE && start_req && hold_q) |=>
        !(state_q == S_WSETUP && op_q == OP_SETUP) &&
        irq_stat_q[IRQ_REFUSED];
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("erase started while lock or supply error pending");

  property p_array_after;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_q == S_RGAP && cnt_end && dev_stat_q[SR_READY_BIT] &&
        auto_array_q) |=> op_q == OP_ARRAY ##1 flash_dq_o == CMD_READ_ARRAY;
  endproperty
  a_array_after: assert property (p_array_after)
    else $error("read array code not written after erase");

endmodule : bsq_ctrl

// ===== bsq_flash_model.sv
`timescale 1ns/1ns
module bsq_flash_model
  import bsq_pkg::*;
#(
  parameter int BUSY = 40
) (
  input  wire logic              clk_sys_i,
  input  wire logic [20:0]       addr_i,
  input  wire logic [DATA_W-1:0] dq_i,
  input  wire logic              ce_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic [7:0]        inj_i,
  output logic      [DATA_W-1:0] dq_o,
  output logic                   array_o
);
  logic [7:0]  sr_q = 8'h80;
  logic [7:0]  lat_q = 8'h00;
  logic [20:0] blk_q = '0;
  logic        we_q = 1'b1;
  logic        sel_q = 1'b0;
  logic        setup_q = 1'b0;
  int          cnt_q = 0;
  logic        sel;
  initial array_o = 1'b1;
  assign sel = !ce_n_i && !oe_n_i;
  // released bus shows the inverse, never a stale copy
  assign dq_o = sel ? (array_o ? 8'hff : lat_q) : ~lat_q;
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    we_q <= we_n_i;
    sel_q <= sel;
    if (sel && !sel_q)
      lat_q <= sr_q;
    if (cnt_q > 1)
      cnt_q <= cnt_q - 1;
    else if (cnt_q == 1) begin
      cnt_q <= 0;
      sr_q <= sr_q | 8'h80 | inj_i;
    end
    if (we_n_i && !we_q && !ce_n_i) begin
      setup_q <= (dq_i == CMD_ERASE_SETUP);
      blk_q <= addr_i;
      array_o <= (dq_i == CMD_READ_ARRAY);
      if (setup_q && (dq_i != CMD_ERASE_CONFIRM || addr_i != blk_q))
        sr_q[5:4] <= 2'b11;
      else if (setup_q && !sr_q[1] && !sr_q[3]) begin
        sr_q[7] <= 1'b0;
        cnt_q <= BUSY;
      end
      if (dq_i == CMD_CLEAR_STATUS)
        sr_q <= sr_q & 8'hc5;
    end
  end
endmodule : bsq_flash_model

// ===== block_erase_status_sequencer_tb.sv
`timescale 1ns/1ns
module block_erase_status_sequencer_tb;
  import bsq_pkg::*;
  localparam logic [7:0] INJ [5] = '{8'h00, 8'h08, 8'h30, 8'h20, 8'h02};
  localparam logic [7:0] EIRQ [5] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h11};
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o, v;
  logic [20:0] f_addr;
  logic [7:0]  f_dq, m_dq, dq_bus;
  logic [7:0]  inj = '0;
  logic        irq_o, f_oe, ce_n, oe_n, we_n, m_arr;
  int          bad_count = 0;
  int          compares = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  assign dq_bus = f_oe ? f_dq : m_dq;
  bsq_ctrl dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o), .flash_addr_o(f_addr), .flash_dq_o(f_dq),
    .flash_dq_oe_o(f_oe), .flash_dq_i(dq_bus), .flash_ce_n_o(ce_n),
    .flash_oe_n_o(oe_n), .flash_we_n_o(we_n));
  bsq_flash_model m (.clk_sys_i(clk_sys_i), .addr_i(f_addr),
    .dq_i(dq_bus), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .inj_i(inj), .dq_o(m_dq), .array_o(m_arr));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(d, e);
  endtask : rdc
  // bounded poll on the busy flag, never a fixed wait
  task automatic wait_idle;
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      rd(REG_CTRL, d);
      n++;
    end while (d[0] !== 1'b0 && n < 400);
    check(32'(d[0]), 32'h0);
  endtask : wait_idle
  task automatic erase(input logic [7:0] e, input logic [20:0] a);
    inj <= e;
    wr(REG_ADDR, 32'(a));
    wr(REG_CTRL, 32'h1);
    wait_idle();
  endtask : erase
  task automatic results;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    bad_count++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    check({ce_n, oe_n, we_n, f_oe}, 32'he);
    rdc(REG_CTRL, 32'h0);
    rdc(REG_IRQ_MASK, 32'h0);
    rdc(4'h9, 32'h0);
    rdc(REG_CFG, 32'h1);
    // read data stands one cycle only, then drops back to zero
    @(posedge clk_sys_i);
    #1 check(reg_rdata_o, 32'h0);
    wr(REG_IRQ_MASK, 32'h3f);
    for (int i = 0; i < 5; i++) begin
      erase(INJ[i], 21'h1e0000 + 21'(i));
      rdc(REG_IRQ_STAT, 32'(EIRQ[i]));
      rdc(REG_DEV_STAT, 32'(INJ[i] | 8'h80));
      rdc(REG_ADDR, 32'h1e0000 + i);
      check(32'(m.blk_q), 32'h1e0000 + i);
      check(32'(m_arr), 32'h1);
      check(32'(irq_o), 32'h1);
      rd(REG_CTRL, v);
      check(32'(v[1]), 32'(INJ[i][1] | INJ[i][3]));
      if (v[1] === 1'b1) begin
        wr(REG_CTRL, 32'h1);
        rdc(REG_CTRL, 32'h2);
        rdc(REG_IRQ_STAT, 32'(EIRQ[i] | 8'h20));
      end
      wr(REG_CTRL, 32'h2);
      wait_idle();
      wr(REG_IRQ_STAT, 32'h3f);
      rdc(REG_CTRL, 32'h0);
      check(32'(irq_o), 32'h0);
    end
    // sticky device error survives a clean second erase
    wr(REG_IRQ_MASK, 32'h0);
    erase(8'h20, 21'h0e000);
    wr(REG_IRQ_STAT, 32'h3f);
    erase(8'h00, 21'h0e000);
    rdc(REG_DEV_STAT, 32'ha0);
    rdc(REG_IRQ_STAT, 32'h09);
    check(32'(irq_o), 32'h0);
    wr(REG_IRQ_MASK, 32'h08);
    rdc(REG_IRQ_MASK, 32'h08);
    check(32'(irq_o), 32'h1);
    wr(REG_IRQ_STAT, 32'h08);
    rdc(REG_IRQ_STAT, 32'h01);
    check(32'(irq_o), 32'h0);
    wr(REG_CTRL, 32'h2);
    wait_idle();
    // without auto read-array the device stays in status mode
    wr(REG_CFG, 32'h0);
    erase(8'h00, 21'h1f0000);
    check(32'(m_arr), 32'h0);
    wr(REG_CTRL, 32'h4);
    wait_idle();
    check(32'(m_arr), 32'h1);
    // reset in the confirm pulse: address held while busy, then all idle
    wr(REG_ADDR, 32'h1e0000);
    wr(REG_CTRL, 32'h1);
    wr(REG_ADDR, 32'h0);
    rdc(REG_ADDR, 32'h1e0000);
    repeat (18) @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    #1 check({ce_n, oe_n, we_n, f_oe}, 32'he);
    rdc(REG_CTRL, 32'h0);
    rdc(REG_IRQ_STAT, 32'h0);
    rdc(REG_ADDR, 32'h0);
    rdc(REG_CFG, 32'h1);
    results();
  end
endmodule : block_erase_status_sequencer_tb
